// *** inc/asa_pkg.sv ***
// Constants, carriers and state codes for the asynchronous serial adapter
package asa_pkg;
  // Bit-rate range and the 16x oversampling divider derived from it
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned BAUD_MIN   = 50;
  localparam int unsigned BAUD_MAX   = 9600;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [15:0] DIV_MAX    = 16'(CLK_HZ / (OVERSAMPLE * BAUD_MIN));
  localparam logic [15:0] DIV_MIN    = 16'(CLK_HZ / (OVERSAMPLE * BAUD_MAX));
  // I/O window: A9 and A7..A3 fixed, A8 compared with the jumper
  localparam logic        WIN_A9     = 1'b1;
  localparam logic [4:0]  WIN_MID    = 5'h1F;
  // Register index on A2..A0
  localparam logic [2:0]  REG_DATA   = 3'h0;
  localparam logic [2:0]  REG_IER    = 3'h1;
  localparam logic [2:0]  REG_IIR    = 3'h2;
  localparam logic [2:0]  REG_LCR    = 3'h3;
  localparam logic [2:0]  REG_MCR    = 3'h4;
  localparam logic [2:0]  REG_LSR    = 3'h5;
  localparam logic [2:0]  REG_MSR    = 3'h6;
  // Interrupt identification codes, highest priority first
  localparam logic [7:0]  IIR_LINE   = 8'h06;
  localparam logic [7:0]  IIR_RXD    = 8'h04;
  localparam logic [7:0]  IIR_THRE   = 8'h02;
  localparam logic [7:0]  IIR_MODEM  = 8'h00;
  localparam logic [7:0]  IIR_NONE   = 8'h01;
  // Field positions
  localparam int unsigned IER_RX     = 0;
  localparam int unsigned IER_TX     = 1;
  localparam int unsigned IER_LS     = 2;
  localparam int unsigned IER_MS     = 3;
  localparam int unsigned MCR_DTR    = 0;
  localparam int unsigned MCR_RTS    = 1;
  localparam int unsigned MCR_OUT1   = 2;
  localparam int unsigned MCR_OUT2   = 3;
  localparam int unsigned MCR_LOOP   = 4;
  // Reset values
  localparam logic [7:0]  LCR_RST    = 8'h00;
  localparam logic [3:0]  IER_RST    = 4'h0;
  localparam logic [4:0]  MCR_RST    = 5'h00;
  localparam logic [15:0] DIV_RST    = DIV_MIN;
  // Oversampling tick positions within a bit
  localparam logic [3:0]  TICK_LAST  = 4'hF;
  localparam logic [3:0]  HALF_BIT   = 4'h7;
  localparam logic [4:0]  STOP_1_END = 5'h0F;
  localparam logic [4:0]  STOP_15_END = 5'h17;
  localparam logic [4:0]  STOP_2_END = 5'h1F;
  localparam int unsigned RX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic       divisor_access_select;
    logic       brk;
    logic       stick;
    logic       eps;
    logic       pen;
    logic       stb;
    logic [1:0] wls;
  } asa_lcr_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } asa_modem_s;

  typedef struct packed {
    logic       pri;
    logic       dma_address_enable;
    logic       rd_n;
    logic       wr_n;
    asa_modem_s mdm;
    logic       rx;
  } asa_pins_s;

  localparam asa_pins_s PINS_RST = 9'h061;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } asa_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_HOLD  = 3'b101
  } asa_rx_e;
endpackage

// *** verilog/asa_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asa_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("asa_fifo: DEPTH must be a power of two and at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = !(wp_r[AW] != rp_r[AW] && wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem_r[rp_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// *** verilog/asa_top.sv ***
// Serial adapter: host I/O decode, registers, transmitter and receiver
`timescale 1ns/1ps
// Overview of operation
// - Jumper picks primary or secondary eight-address window
// - Low three address bits select the register
// - Divisor-access bit redirects offsets zero and one
// - Framing bits added on send, stripped on receive
// - Programmable divider sets bit rate across range
// - Five to eight data bits, 1/1.5/2 stops
// - Prioritised interrupt causes: line, receive, transmit, modem
// - Loopback routes serial and modem signals internally
// - One holding character beside the transmit shifter; receive has a FIFO plus a holding register
// - Drive RTS/DTR, sense CTS/DSR/RI/DCD
// - Force break on transmit, detect received break
// - Address line eight matches jumper to select window
// - Interrupt output needs modem-control bit 3 set
// - Data bit zero travels first after start
module asa_top
  import asa_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Host I/O channel
  input  wire logic [9:0] io_addr,
  input  wire logic [7:0] io_data_in,
  output logic [7:0]      io_data_out,
  output logic            io_data_oe,
  input  wire logic       io_rd_n,
  input  wire logic       io_wr_n,
  input  wire logic       dma_address_enable,
  output logic            primary_interrupt_line,
  output logic            alternate_interrupt_line,
  // Address jumper
  input  wire logic       primary_select,
  // Serial line and modem
  input  wire logic       rx_data,
  output logic            tx_data,
  output logic            rts,
  output logic            dtr,
  input  wire logic       cts,
  input  wire logic       dsr,
  input  wire logic       ri,
  input  wire logic       dcd
);
  asa_pins_s  sy1_r;
  asa_pins_s  sy2_r;
  asa_lcr_s   lcr_r;
  logic [3:0] ier_r;
  logic [4:0] mcr_r;
  logic [15:0] div_r;
  logic [15:0] bcnt_r;
  logic       tick;
  logic       rd_s;
  logic       wr_s;
  logic       rd_q_r;
  logic       wr_q_r;
  logic       sel;
  logic       rd_go;
  logic       wr_go;
  logic [2:0] ra;
  logic       loop;
  logic [2:0] nb_m1;
  logic [4:0] stop_end;
  logic [7:0] thr_r;
  logic       thre_r;
  logic       thri_r;
  logic       wr_thr;
  logic       tx_load;
  asa_tx_e    tx_st_r;
  logic [4:0] tx_tk_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_par_r;
  logic       tx_ln_r;
  logic       tx_eff;
  asa_rx_e    rx_st_r;
  logic [3:0] rx_tk_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_pb_r;
  logic       rx_fe_r;
  logic       rx_done_r;
  logic       rx_in;
  logic [7:0] rx_char;
  logic       f_rdy;
  logic       f_vld;
  logic [7:0] f_data;
  logic       pop;
  logic [7:0] rbr_r;
  logic       dr_r;
  logic       oe_f_r;
  logic       pe_f_r;
  logic       fe_f_r;
  logic       bi_f_r;
  asa_modem_s mdm;
  asa_modem_s mdm_q_r;
  asa_modem_s dlt_r;
  asa_modem_s chg;
  logic [7:0] lsr;
  logic [7:0] iir;
  logic       ls_int;
  logic       irq;
  logic       rd_rbr;
  logic       rd_lsr;
  logic       rd_msr;
  logic       rd_iir;
  logic [7:0] rdata_nxt;

  function automatic logic par_of(input logic [7:0] d, input asa_lcr_s l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l.wls));
    if (l.stick) begin
      return !l.eps;
    end
    return l.eps ? ^m : ~^m;
  endfunction

  // Strobe, enable, jumper, serial and modem pins pass two flops; address and data go straight to logic
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sy1_r <= PINS_RST;
      sy2_r <= PINS_RST;
    end else begin
      sy1_r <= {primary_select, dma_address_enable, io_rd_n, io_wr_n,
                dcd, ri, dsr, cts, rx_data};
      sy2_r <= sy1_r;
    end
  end

  // Address and data must be stable while the strobe is low
  assign rd_s  = !sy2_r.rd_n;
  assign wr_s  = !sy2_r.wr_n;
  assign sel   = !sy2_r.dma_address_enable && io_addr[9] == WIN_A9 &&
                 io_addr[8] == sy2_r.pri &&
                 io_addr[7:3] == WIN_MID;
  assign rd_go = rd_s && !rd_q_r && sel;
  assign wr_go = wr_s && !wr_q_r && sel;
  assign ra    = io_addr[2:0];
  assign loop  = mcr_r[MCR_LOOP];
  assign nb_m1 = 3'h4 + {1'b0, lcr_r.wls};
  assign stop_end = !lcr_r.stb ? STOP_1_END :
                    (lcr_r.wls == 2'h0 ? STOP_15_END : STOP_2_END);

  assign wr_thr = wr_go && ra == REG_DATA && !lcr_r.divisor_access_select;
  assign rd_rbr = rd_go && ra == REG_DATA && !lcr_r.divisor_access_select;
  assign rd_lsr = rd_go && ra == REG_LSR;
  assign rd_msr = rd_go && ra == REG_MSR;
  assign rd_iir = rd_go && ra == REG_IIR;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
    end else begin
      rd_q_r <= rd_s;
      wr_q_r <= wr_s;
    end
  end

  // Control registers written by the host
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lcr_r <= LCR_RST;
      ier_r <= IER_RST;
      mcr_r <= MCR_RST;
      div_r <= DIV_RST;
    end else if (wr_go) begin
      case (ra)
        REG_DATA: if (lcr_r.divisor_access_select) begin
          div_r[7:0] <= io_data_in;
        end
        REG_IER: if (lcr_r.divisor_access_select) begin
          div_r[15:8] <= io_data_in;
        end else begin
          ier_r <= io_data_in[3:0];
        end
        REG_LCR: lcr_r <= io_data_in;
        REG_MCR: mcr_r <= io_data_in[4:0];
        default: ;
      endcase
    end
  end

  // 16x tick; divisor zero stops the line
  assign tick = div_r != 16'h0000 && bcnt_r >= div_r - 16'h0001;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_r <= 16'h0000;
    end else begin
      bcnt_r <= (tick || div_r == 16'h0000) ? 16'h0000 : bcnt_r + 16'h0001;
    end
  end

  // Transmit holding register
  assign tx_load = tx_st_r == TX_IDLE && !thre_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      thr_r  <= 8'h00;
      thre_r <= 1'b1;
    end else if (wr_thr) begin
      thr_r  <= io_data_in;
      thre_r <= 1'b0;
    end else if (tx_load) begin
      thre_r <= 1'b1;
    end
  end

  // Transmitter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_r  <= TX_IDLE;
      tx_tk_r  <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      tx_par_r <= 1'b0;
      tx_ln_r  <= 1'b1;
    end else if (tx_load) begin
      tx_st_r  <= TX_START;
      tx_sh_r  <= thr_r;
      tx_par_r <= par_of(thr_r, lcr_r);
      tx_tk_r  <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_ln_r  <= 1'b0;
    end else if (tick && tx_st_r != TX_IDLE) begin
      tx_tk_r <= tx_tk_r + 5'h01;
      case (tx_st_r)
        TX_START: if (tx_tk_r[3:0] == TICK_LAST) begin
          tx_st_r <= TX_DATA;
          tx_tk_r <= 5'h00;
          tx_ln_r <= tx_sh_r[0];
        end
        TX_DATA: if (tx_tk_r[3:0] == TICK_LAST) begin
          tx_tk_r <= 5'h00;
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          if (tx_bit_r == nb_m1) begin
            tx_st_r <= lcr_r.pen ? TX_PAR : TX_STOP;
            tx_ln_r <= lcr_r.pen ? tx_par_r : 1'b1;
          end else begin
            tx_bit_r <= tx_bit_r + 3'h1;
            tx_ln_r  <= tx_sh_r[1];
          end
        end
        TX_PAR: if (tx_tk_r[3:0] == TICK_LAST) begin
          tx_st_r <= TX_STOP;
          tx_tk_r <= 5'h00;
          tx_ln_r <= 1'b1;
        end
        TX_STOP: if (tx_tk_r == stop_end) begin
          tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Receiver; loopback feeds it from the transmitter
  assign tx_eff  = lcr_r.brk ? 1'b0 : tx_ln_r;
  assign rx_in   = loop ? tx_eff : sy2_r.rx;
  assign rx_char = rx_sh_r >> (2'h3 - lcr_r.wls);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_r   <= RX_IDLE;
      rx_tk_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_pb_r   <= 1'b0;
      rx_fe_r   <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (tick) begin
        rx_tk_r <= rx_tk_r + 4'h1;
      end
      case (rx_st_r)
        RX_IDLE: if (!rx_in) begin
          rx_st_r <= RX_START;
          rx_tk_r <= 4'h0;
        end
        RX_START: if (tick && rx_tk_r == HALF_BIT) begin
          rx_tk_r  <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_st_r  <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (tick && rx_tk_r == TICK_LAST) begin
          rx_sh_r <= {rx_in, rx_sh_r[7:1]};
          if (rx_bit_r == nb_m1) begin
            rx_st_r <= lcr_r.pen ? RX_PAR : RX_STOP;
          end else begin
            rx_bit_r <= rx_bit_r + 3'h1;
          end
        end
        RX_PAR: if (tick && rx_tk_r == TICK_LAST) begin
          rx_pb_r <= rx_in;
          rx_st_r <= RX_STOP;
        end
        RX_STOP: if (tick && rx_tk_r == TICK_LAST) begin
          rx_done_r <= 1'b1;
          rx_fe_r   <= !rx_in;
          rx_st_r   <= rx_in ? RX_IDLE : RX_HOLD;
        end
        // A break must return to mark before a new start counts
        RX_HOLD: if (rx_in) begin
          rx_st_r <= RX_IDLE;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  asa_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (rx_done_r),
    .in_ready  (f_rdy),
    .in_data   (rx_char),
    .out_valid (f_vld),
    .out_ready (!dr_r || rd_rbr),
    .out_data  (f_data)
  );

  // Receive holding register refills from the FIFO
  assign pop = f_vld && (!dr_r || rd_rbr);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rbr_r <= 8'h00;
      dr_r  <= 1'b0;
    end else if (pop) begin
      rbr_r <= f_data;
      dr_r  <= 1'b1;
    end else if (rd_rbr) begin
      dr_r <= 1'b0;
    end
  end

  // Sticky line and modem flags: a new event beats the read that clears
  assign mdm = loop ? {mcr_r[MCR_OUT2], mcr_r[MCR_OUT1], mcr_r[MCR_DTR],
                       mcr_r[MCR_RTS]} : sy2_r.mdm;
  assign chg = {mdm.dcd ^ mdm_q_r.dcd, mdm_q_r.ri && !mdm.ri,
                mdm.dsr ^ mdm_q_r.dsr, mdm.cts ^ mdm_q_r.cts};
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oe_f_r  <= 1'b0;
      pe_f_r  <= 1'b0;
      fe_f_r  <= 1'b0;
      bi_f_r  <= 1'b0;
      mdm_q_r <= 4'h0;
      dlt_r   <= 4'h0;
    end else begin
      oe_f_r  <= (rx_done_r && !f_rdy) || (oe_f_r && !rd_lsr);
      pe_f_r  <= (rx_done_r && lcr_r.pen && rx_pb_r != par_of(rx_char, lcr_r)) ||
                 (pe_f_r && !rd_lsr);
      fe_f_r  <= (rx_done_r && rx_fe_r) || (fe_f_r && !rd_lsr);
      bi_f_r  <= (rx_done_r && rx_fe_r && rx_char == 8'h00 &&
                  !(lcr_r.pen && rx_pb_r)) || (bi_f_r && !rd_lsr);
      mdm_q_r <= mdm;
      dlt_r   <= chg | (dlt_r & {4{!rd_msr}});
    end
  end

  // Interrupt identification in fixed priority order
  assign lsr    = {1'b0, thre_r && tx_st_r == TX_IDLE, thre_r, bi_f_r, fe_f_r,
                   pe_f_r, oe_f_r, dr_r};
  assign ls_int = ier_r[IER_LS] && |lsr[4:1];
  always_comb begin
    if (ls_int) begin
      iir = IIR_LINE;
    end else if (ier_r[IER_RX] && dr_r) begin
      iir = IIR_RXD;
    end else if (ier_r[IER_TX] && thri_r) begin
      iir = IIR_THRE;
    end else if (ier_r[IER_MS] && |dlt_r) begin
      iir = IIR_MODEM;
    end else begin
      iir = IIR_NONE;
    end
  end
  assign irq = !iir[0] && mcr_r[MCR_OUT2];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      thri_r <= 1'b0;
    end else begin
      thri_r <= tx_load || (wr_go && ra == REG_IER && !lcr_r.divisor_access_select &&
                io_data_in[IER_TX] && !ier_r[IER_TX] && thre_r) ||
                (thri_r && !wr_thr && !(rd_iir && iir == IIR_THRE));
    end
  end

  always_comb begin
    case (ra)
      REG_DATA: rdata_nxt = lcr_r.divisor_access_select ? div_r[7:0] : rbr_r;
      REG_IER:  rdata_nxt = lcr_r.divisor_access_select ? div_r[15:8] : {4'h0, ier_r};
      REG_IIR:  rdata_nxt = iir;
      REG_LCR:  rdata_nxt = lcr_r;
      REG_MCR:  rdata_nxt = {3'h0, mcr_r};
      REG_LSR:  rdata_nxt = lsr;
      REG_MSR:  rdata_nxt = {mdm, dlt_r};
      default:  rdata_nxt = 8'h00;
    endcase
  end

  // Pin outputs; driver drops on the clock after the two-flop synchronised strobe goes away or the enable rises
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      io_data_out <= 8'h00;
      io_data_oe  <= 1'b0;
      tx_data     <= 1'b1;
      rts         <= 1'b0;
      dtr         <= 1'b0;
      primary_interrupt_line   <= 1'b0;
      alternate_interrupt_line <= 1'b0;
    end else begin
      if (rd_go) begin
        io_data_out <= rdata_nxt;
      end
      io_data_oe  <= rd_go || (io_data_oe && rd_s && !sy2_r.dma_address_enable);
      tx_data     <= loop || tx_eff;
      rts         <= mcr_r[MCR_RTS] && !loop;
      dtr         <= mcr_r[MCR_DTR] && !loop;
      primary_interrupt_line   <= irq && sy2_r.pri;
      alternate_interrupt_line <= irq && !sy2_r.pri;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_OE_ONLY_ON_READ: assert property (!rd_s |=> !io_data_oe)
    else $error("data driver on without read strobe");
  AST_WINDOW_READ: assert property (
    rd_go |=> io_data_oe && io_data_out == $past(rdata_nxt))
    else $error("selected read not answered");
  AST_LCR_READBACK: assert property (
    rd_go && ra == REG_LCR |=> io_data_out == $past(lcr_r))
    else $error("line control readback wrong");
  AST_DIV_REDIRECT: assert property (
    wr_go && ra == REG_DATA && lcr_r.divisor_access_select |=>
      div_r[7:0] == $past(io_data_in) && thr_r == $past(thr_r))
    else $error("divisor write disturbed holding register");
  AST_TICK_SPACING: assert property (tick && div_r > 16'h0001 |=> !tick)
    else $error("bit-rate ticks too close");
  AST_FIRST_BIT: assert property (
    tx_st_r == TX_START && tick && tx_tk_r[3:0] == TICK_LAST |=> tx_ln_r == $past(tx_sh_r[0]))
    else $error("first data bit is not bit zero");
  AST_STOP_MARK: assert property (tx_st_r == TX_STOP |-> tx_ln_r)
    else $error("stop bit not marking");
  AST_LAST_DATA: assert property (
    tx_st_r == TX_DATA && tick && tx_tk_r[3:0] == TICK_LAST && tx_bit_r == nb_m1 &&
      !lcr_r.pen |=> tx_st_r == TX_STOP)
    else $error("character length wrong");
  AST_HOLD_LOAD: assert property (
    tx_load |=> tx_st_r == TX_START && tx_sh_r == $past(thr_r) ##1 tx_data == $past(loop))
    else $error("holding register not moved to shifter");
  AST_PRIORITY: assert property (ls_int && dr_r && ier_r[IER_RX] |-> iir == IIR_LINE)
    else $error("line status not highest priority");
  AST_IRQ_GATE: assert property (
    primary_interrupt_line || alternate_interrupt_line |->
      $past(mcr_r[MCR_OUT2]) && !$past(iir[0]))
    else $error("interrupt raised without gate or cause");
  AST_WIN_A8: assert property (
    rd_s && !rd_q_r && io_addr[8] != sy2_r.pri |=> !io_data_oe)
    else $error("read answered outside window");
  AST_BREAK_OUT: assert property (lcr_r.brk && !loop |=> !tx_data)
    else $error("break not forced on line");
  AST_LOOP_OUT: assert property (loop |=> tx_data && !rts && !dtr)
    else $error("loopback leaks to pins");
  AST_FALSE_START: assert property (
    rx_st_r == RX_START && tick && rx_tk_r == HALF_BIT && rx_in |=> rx_st_r == RX_IDLE)
    else $error("false start not discarded");
  AST_RTS_FOLLOW: assert property (
    !loop ##1 !loop |-> rts == $past(mcr_r[MCR_RTS]))
    else $error("request to send not following control");

  COV_FALSE_START: cover property (rx_st_r == RX_START ##1 rx_st_r == RX_IDLE);
  COV_RX_CHAR: cover property (rx_done_r && !rx_fe_r);
  COV_BREAK: cover property (bi_f_r);
  COV_IRQ: cover property (primary_interrupt_line);
endmodule

// *** verif/asa_peer.sv ***
// Serial peer model: sends and receives 8N1 frames at a fixed bit time
`timescale 1ns/1ps
module asa_peer #(
  parameter int BIT = 32
) (
  // Clock
  input  wire logic  ref_clk,
  // Serial line
  input  wire logic  line_in,
  output logic       line_out,
  // Last character received
  output logic [7:0] got
);
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (BIT) @(posedge ref_clk);
      #1;
    end
  endtask
  // Samples mid-bit, like a real receiver would
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge ref_clk);
  end
endmodule

// *** verif/asa_top_tb.sv ***
// Self-checking bench for the serial adapter
`timescale 1ns/1ps
module asa_top_tb;
  import asa_pkg::*;
  localparam int BIT = 32;
  logic       ref_clk, resetn, io_rd_n, io_wr_n, dma_en, tx_data, rx_data;
  logic       rts, dtr, oe, oe_s, irq_p, irq_a, pri_sel;
  logic [9:0] addr;
  logic [7:0] din, dout, rd;
  logic [3:0] mdm;
  int         err_total, n_compared;
  asa_top #(.FIFO_DEPTH(16)) uut (.ref_clk(ref_clk), .resetn(resetn), .io_addr(addr),
    .io_data_in(din), .io_data_out(dout), .io_data_oe(oe), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .dma_address_enable(dma_en), .primary_interrupt_line(irq_p),
    .alternate_interrupt_line(irq_a), .primary_select(pri_sel), .rx_data(rx_data),
    .tx_data(tx_data), .rts(rts), .dtr(dtr), .cts(mdm[0]), .dsr(mdm[1]), .ri(mdm[2]),
    .dcd(mdm[3]));
  asa_peer #(.BIT(BIT)) peer (.ref_clk(ref_clk), .line_in(tx_data), .line_out(rx_data),
    .got());
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Strobe held 4 edges so the answer after the third edge is settled
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
    addr = a;
    din = d;
    if (wr) io_wr_n = 1'b0;
    else io_rd_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rd = dout;
    oe_s = oe;
    #1 io_wr_n = 1'b1;
    io_rd_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_reset;
    acc(0, 10'h3FD, 0); chk(rd, 8'h60);
    acc(0, 10'h3FA, 0); chk(rd, IIR_NONE);
    acc(0, 10'h3FE, 0); chk({rd[7:4], 4'h0}, 8'hA0);
  endtask
  task automatic t_decode;
    dma_en = 1'b1;
    acc(0, 10'h3FB, 0); chk({7'h00, oe_s}, 8'h00);
    dma_en = 1'b0;
    acc(0, 10'h2FB, 0); chk({7'h00, oe_s}, 8'h00);
    acc(1, 10'h3FB, 8'h83);
    acc(1, 10'h3F8, 8'h02);
    acc(1, 10'h3F9, 8'h00);
    acc(0, 10'h3F8, 0); chk(rd, 8'h02);
    acc(1, 10'h3FB, 8'h03);
    acc(0, 10'h3FB, 0); chk(rd, 8'h03);
    // Jumper moved to the alternate window
    pri_sel = 1'b0;
    acc(0, 10'h3FB, 0); chk({7'h00, oe_s}, 8'h00);
    acc(0, 10'h2FB, 0); chk(rd, 8'h03);
    pri_sel = 1'b1;
  endtask
  task automatic t_tx;
    acc(1, 10'h3F8, 8'hA5);
    repeat (12 * BIT) @(posedge ref_clk);
    chk(peer.got, 8'hA5);
    acc(1, 10'h3FB, 8'h43);
    chk({7'h00, tx_data}, 8'h00);
    acc(1, 10'h3FB, 8'h03);
    repeat (12 * BIT) @(posedge ref_clk);
  endtask
  task automatic t_rx;
    int n;
    acc(1, 10'h3F9, 8'h01);
    acc(1, 10'h3FC, 8'h08);
    peer.send(8'h3C);
    for (n = 0; n < 4 * BIT && irq_p !== 1'b1; n++) @(posedge ref_clk);
    chk({6'h00, irq_p, irq_a}, 8'h02);
    acc(0, 10'h3FA, 0); chk(rd, IIR_RXD);
    acc(0, 10'h3F8, 0); chk(rd, 8'h3C);
    acc(0, 10'h3FA, 0); chk(rd, IIR_NONE);
    // Start pulse shorter than half a bit
    peer.line_out = 1'b0;
    repeat (BIT / 4) @(posedge ref_clk);
    #1 peer.line_out = 1'b1;
    repeat (12 * BIT) @(posedge ref_clk);
    acc(0, 10'h3FD, 0); chk(rd, 8'h60);
  endtask
  task automatic t_loop;
    acc(1, 10'h3FC, 8'h03);
    chk({6'h00, dtr, rts}, 8'h03);
    acc(1, 10'h3FC, 8'h13);
    acc(0, 10'h3FE, 0); chk({rd[7:4], 4'h0}, 8'h30);
    chk({5'h00, dtr, rts, tx_data}, 8'h01);
    acc(1, 10'h3F8, 8'h5A);
    repeat (12 * BIT) @(posedge ref_clk);
    acc(0, 10'h3F8, 0); chk(rd, 8'h5A);
    // Five bits, even parity, one and a half stops
    acc(1, 10'h3FB, 8'h1C);
    acc(1, 10'h3F8, 8'h35);
    repeat (12 * BIT) @(posedge ref_clk);
    acc(0, 10'h3F8, 0); chk(rd, 8'h15);
    acc(0, 10'h3FD, 0); chk(rd, 8'h60);
    // Looped break arrives as an all-zero character with framing error
    acc(1, 10'h3FB, 8'h43);
    repeat (12 * BIT) @(posedge ref_clk);
    acc(1, 10'h3FB, 8'h03);
    repeat (BIT) @(posedge ref_clk);
    acc(0, 10'h3FD, 0); chk(rd, 8'h79);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #400us;
    err_total++;
    test_done();
  end
  initial begin
    resetn = 0; io_rd_n = 1; io_wr_n = 1; dma_en = 0; addr = 0; din = 0; mdm = 4'hA;
    pri_sel = 1;
    err_total = 0; n_compared = 0;
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_decode();
    t_tx();
    t_rx();
    t_loop();
    test_done();
  end
endmodule
